// File: bench/cbu_testbench.sv
// self-checking bench for the conditional branch unit
`timescale 1ns/1ns
module testbench;
  import cbu_pkg::*;
  logic              ref_clk = 1'b0;
  logic              srst = 1'b1;
  logic              issue = 1'b0;
  logic [2:0]        op = 3'h0;
  logic [IDX_W-1:0]  flag_idx = '0;
  logic [OFS_W-1:0]  offset = '0;
  logic [PC_W-1:0]   pc_in = '0;
  logic [STAT_W-1:0] status_in = '0;
  logic              busy_r;
  logic              done_r;
  logic              taken_r;
  logic [PC_W-1:0]   pc_out_r;
  logic [STAT_W-1:0] status_out_r;
  logic [31:0]       r1;
  logic [31:0]       r2;
  int                mismatches = 0;
  int                total_checks = 0;
  int                cycles = 0;
  integer            seed = 54517;

  // 125 MHz core clock
  always #4 ref_clk = ~ref_clk;

  cbu_branch_unit u_dut (
    .ref_clk      (ref_clk),
    .srst         (srst),
    .issue        (issue),
    .op           (op),
    .flag_idx     (flag_idx),
    .offset       (offset),
    .pc_in        (pc_in),
    .status_in    (status_in),
    .busy_r       (busy_r),
    .done_r       (done_r),
    .taken_r      (taken_r),
    .pc_out_r     (pc_out_r),
    .status_out_r (status_out_r)
  );

  // branch condition as the opcode table defines it; code 7 never branches
  function automatic logic cond_f(logic [2:0] o, logic [IDX_W-1:0] i, logic [STAT_W-1:0] s);
    case (o)
      3'h0: return s[i];
      3'h1: return !s[i];
      3'h2: return s[STAT_EQ_BIT];
      3'h3: return !s[STAT_EQ_BIT];
      3'h4: return s[STAT_OVF_BIT];
      3'h5, 3'h6: return !s[STAT_OVF_BIT];
      default: return 1'b0;
    endcase
  endfunction

  // sign-extended offset plus one, wrapping at pc width
  function automatic logic [PC_W-1:0] target_f(logic [PC_W-1:0] p, logic [OFS_W-1:0] k);
    return p + PC_W'($signed(k)) + PC_STEP;
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // one branch, issue held for the accept edge only
  task automatic run_op(input logic [2:0] o, input logic [IDX_W-1:0] i,
                        input logic [OFS_W-1:0] k, input logic [PC_W-1:0] p,
                        input logic [STAT_W-1:0] s);
    logic            t;
    logic [PC_W-1:0] nxt;
    t = cond_f(o, i, s);
    nxt = t ? target_f(p, k) : p + PC_STEP;
    @(posedge ref_clk);
    #1;
    op = o;
    flag_idx = i;
    offset = k;
    pc_in = p;
    status_in = s;
    issue = 1'b1;
    @(posedge ref_clk);
    #1;
    issue = 1'b0;
    // inputs are scrambled now so a late sample would show
    status_in = ~s;
    pc_in = ~p;
    if (t) begin
      check(busy_r, 1'b1, "busy in taken branch");
      check(done_r, 1'b0, "early done");
      @(posedge ref_clk);
      #1;
    end
    check(done_r, 1'b1, "done");
    check(taken_r, t, "taken flag");
    check(pc_out_r, nxt, "next pc");
    check(status_out_r, s, "status copy");
    check(busy_r, 1'b0, "busy at finish");
    @(posedge ref_clk);
    #1;
    check(done_r, 1'b0, "done pulse width");
    check(taken_r, 1'b0, "taken pulse width");
  endtask

  // hang guard, generous against roughly twelve hundred cycles of tests
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // main sequence: reset, tables, corners, random
  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    check(done_r, 1'b0, "done after reset");
    check(pc_out_r, PC_RST, "pc after reset");
    for (int o = 0; o < 8; o++) begin
      run_op(o[2:0], 3'h2, 7'h05, 12'h100, 8'h00);
      run_op(o[2:0], 3'h5, 7'h7b, 12'h100, 8'hff);
    end
    // lone set bit, then lone clear bit: a wrong index lookup cannot pass
    for (int i = 0; i < 8; i++) begin
      run_op(3'h0, i[2:0], 7'h11, 12'h3a0, 8'h01 << i);
      run_op(3'h1, i[2:0], 7'h11, 12'h3a0, 8'h01 << i);
      run_op(3'h1, i[2:0], 7'h22, 12'h3a0, ~(8'h01 << i));
    end
    run_op(3'h2, 3'h0, 7'h40, 12'h010, 8'h02);
    run_op(3'h2, 3'h0, 7'h3f, 12'hfff, 8'h02);
    // back to back not-taken branches
    @(posedge ref_clk);
    #1;
    op = 3'h2;
    status_in = 8'h00;
    pc_in = 12'h123;
    issue = 1'b1;
    @(posedge ref_clk);
    #1;
    check(pc_out_r, 12'h124, "first of pair");
    check(done_r, 1'b1, "first of pair done");
    op = 3'h3;
    status_in = 8'h02;
    pc_in = 12'h200;
    @(posedge ref_clk);
    #1;
    issue = 1'b0;
    check(done_r, 1'b1, "second of pair done");
    check(pc_out_r, 12'h201, "second of pair pc");
    // issue held into the busy cycle must not start a second branch
    @(posedge ref_clk);
    #1;
    op = 3'h3;
    status_in = 8'h00;
    pc_in = 12'h080;
    offset = 7'h10;
    issue = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    issue = 1'b0;
    check(done_r, 1'b1, "held issue done");
    check(pc_out_r, 12'h091, "held issue target");
    @(posedge ref_clk);
    #1;
    check(done_r, 1'b0, "held issue not replayed");
    // reset while a taken branch is busy drops it with no late finish
    @(posedge ref_clk);
    #1;
    op = 3'h1;
    flag_idx = 3'h0;
    status_in = 8'h00;
    pc_in = 12'h050;
    issue = 1'b1;
    @(posedge ref_clk);
    #1;
    issue = 1'b0;
    srst = 1'b1;
    @(posedge ref_clk);
    #1;
    srst = 1'b0;
    check(busy_r, 1'b0, "busy after mid reset");
    check(pc_out_r, PC_RST, "pc after mid reset");
    check(status_out_r, STAT_RST, "status after mid reset");
    @(posedge ref_clk);
    #1;
    check(done_r, 1'b0, "no finish after mid reset");
    check(taken_r, 1'b0, "no taken after mid reset");
    repeat (300) begin
      r1 = $random(seed);
      r2 = $random(seed);
      run_op(r1[2:0], r1[5:3], r1[12:6], r1[24:13], r2[7:0]);
    end
    report_and_stop();
  end
endmodule

// File: include/cbu_pkg.sv
// constants and types shared by the conditional branch unit
// Notes on behaviour
// - flag-set branch jumps to pc plus offset plus one when the indexed status bit is one.
// - flag-cleared branch jumps only when the indexed status bit is zero, else falls through.
// - equal branch jumps when the equality flag is one and uses no flag index.
// - unequal branch jumps when the equality flag is zero.
// - overflow-one branch jumps on overflow flag one, overflow-zero branch on flag zero.
// - unsigned at-least branch jumps when the overflow flag is zero.
// - no branch alters any status flag; one cycle when not taken, two when taken.
package cbu_pkg;
  localparam int PC_W   = 12; // program counter width in bits
  localparam int OFS_W  = 7;  // signed branch offset width
  localparam int STAT_W = 8;  // status_register width
  localparam int IDX_W  = 3;  // flag index width

  // bit positions inside status_register
  localparam logic [IDX_W-1:0] STAT_OVF_BIT = 3'h0; // unsigned overflow flag
  localparam logic [IDX_W-1:0] STAT_EQ_BIT  = 3'h1; // equality result flag

  localparam logic [PC_W-1:0]   PC_RST   = 12'h000;
  localparam logic [PC_W-1:0]   PC_STEP  = 12'h001;
  localparam logic [STAT_W-1:0] STAT_RST = 8'h00;

  typedef enum logic [2:0] {
    branch_on_flag_set,
    branch_on_flag_cleared,
    branch_if_equal,
    branch_if_unequal,
    branch_on_overflow_one,
    branch_on_overflow_zero,
    branch_unsigned_at_least
  } cbu_op_e;

  typedef enum logic {
    CBU_ST_IDLE,
    CBU_ST_JUMP
  } cbu_state_e;
endpackage

// File: src/cbu_branch_unit.sv
// conditional relative branch execution unit, top level
`timescale 1ns/1ns
module cbu_branch_unit
  import cbu_pkg::*;
(
  input  wire logic                       ref_clk,
  input  wire logic                       srst,
  input  wire logic                       issue,
  input  wire logic [2:0]                 op,
  input  wire logic [cbu_pkg::IDX_W-1:0]  flag_idx,
  input  wire logic [cbu_pkg::OFS_W-1:0]  offset,
  input  wire logic [cbu_pkg::PC_W-1:0]   pc_in,
  input  wire logic [cbu_pkg::STAT_W-1:0] status_in,
  output logic                            busy_r,
  output logic                            done_r,
  output logic                            taken_r,
  output logic [cbu_pkg::PC_W-1:0]        pc_out_r,
  output logic [cbu_pkg::STAT_W-1:0]      status_out_r
);
  cbu_state_e            state_r;
  cbu_state_e            state_nxt;
  logic [PC_W-1:0]       target_r;
  logic                  cond_met;
  logic [PC_W-1:0]       target;

  cbu_cond_eval u_eval (
    .op              (op),
    .flag_idx        (flag_idx),
    .status_register (status_in),
    .pc_in           (pc_in),
    .offset          (offset),
    .cond_met        (cond_met),
    .target          (target)
  );

  // issue is only taken while idle; the busy cycle of a taken branch ignores it
  wire logic accept    = issue && (state_r == CBU_ST_IDLE);
  wire logic go_jump   = accept && cond_met;
  wire logic fall_thru = accept && !cond_met;
  wire logic jump_end  = (state_r == CBU_ST_JUMP);
  wire logic [PC_W-1:0] seq_pc = pc_in + PC_STEP;

  // two-state sequence: taken branch spends an extra cycle
  always_comb begin
    case (state_r)
      CBU_ST_IDLE: state_nxt = go_jump ? CBU_ST_JUMP : CBU_ST_IDLE;
      CBU_ST_JUMP: state_nxt = CBU_ST_IDLE;
      default:     state_nxt = CBU_ST_IDLE;
    endcase
  end

  // state and held target
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r  <= CBU_ST_IDLE;
      target_r <= PC_RST;
    end else begin
      state_r <= state_nxt;
      if (go_jump) begin
        target_r <= target;
      end
    end
  end

  // handshake outputs; done marks the last cycle of the instruction
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
      taken_r <= 1'b0;
    end else begin
      busy_r  <= go_jump;
      done_r  <= fall_thru || jump_end;
      taken_r <= jump_end;
    end
  end

  // next pc: sequential after one cycle, target after two
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pc_out_r <= PC_RST;
    end else if (fall_thru) begin
      pc_out_r <= seq_pc;
    end else if (jump_end) begin
      pc_out_r <= target_r;
    end
  end

  // flags pass through untouched; branches never write status
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_out_r <= STAT_RST;
    end else if (accept) begin
      status_out_r <= status_in;
    end
  end

  // ---------------- assertions ----------------
  sequence s_accept_taken;
    issue && (state_r == CBU_ST_IDLE) && cond_met;
  endsequence

  sequence s_two_cycle_finish;
    busy_r && !done_r ##1 done_r && taken_r && !busy_r;
  endsequence

  property p_taken_two;
    @(posedge ref_clk) disable iff (srst)
      s_accept_taken |=> s_two_cycle_finish;
  endproperty
  a_taken_two: assert property (p_taken_two) else $error("taken branch not two cycles");

  property p_not_taken_one;
    @(posedge ref_clk) disable iff (srst)
      (issue && state_r == CBU_ST_IDLE && !cond_met) |=>
        (done_r && !taken_r && !busy_r && pc_out_r == $past(pc_in) + PC_STEP);
  endproperty
  a_not_taken_one: assert property (p_not_taken_one) else $error("fall through wrong");

  property p_target_value;
    @(posedge ref_clk) disable iff (srst)
      s_accept_taken |-> ##2 (pc_out_r == $past(target, 2));
  endproperty
  a_target_value: assert property (p_target_value) else $error("branch target wrong");

  // stepping back from the target must leave the offset, sign-extended
  // independently of how the adder builds it
  property p_sign_ext;
    @(posedge ref_clk) disable iff (srst)
      PC_W'(target - pc_in - PC_STEP) == PC_W'($signed(offset));
  endproperty
  a_sign_ext: assert property (p_sign_ext) else $error("offset not sign extended");

  property p_flag_set;
    @(posedge ref_clk) disable iff (srst)
      (issue && state_r == CBU_ST_IDLE && op == branch_on_flag_set) |->
        (cond_met == status_in[flag_idx]);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag set test wrong");

  property p_flag_clr;
    @(posedge ref_clk) disable iff (srst)
      (issue && state_r == CBU_ST_IDLE && op == branch_on_flag_cleared) |=>
        (busy_r == !$past(status_in[flag_idx]));
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag clear test wrong");

  property p_equal;
    @(posedge ref_clk) disable iff (srst)
      (issue && state_r == CBU_ST_IDLE && op == branch_if_equal) |=>
        (busy_r == $past(status_in[STAT_EQ_BIT]));
  endproperty
  a_equal: assert property (p_equal) else $error("equal branch wrong");

  property p_unequal;
    @(posedge ref_clk) disable iff (srst)
      (issue && state_r == CBU_ST_IDLE && op == branch_if_unequal) |->
        (cond_met != status_in[STAT_EQ_BIT]);
  endproperty
  a_unequal: assert property (p_unequal) else $error("unequal branch wrong");

  property p_ovf;
    @(posedge ref_clk) disable iff (srst)
      (issue && state_r == CBU_ST_IDLE && (op == branch_on_overflow_one ||
        op == branch_on_overflow_zero)) |->
        (cond_met == (status_in[STAT_OVF_BIT] == (op == branch_on_overflow_one)));
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow branch wrong");

  property p_at_least;
    @(posedge ref_clk) disable iff (srst)
      (issue && state_r == CBU_ST_IDLE && op == branch_unsigned_at_least) |=>
        (busy_r == !$past(status_in[STAT_OVF_BIT]));
  endproperty
  a_at_least: assert property (p_at_least) else $error("unsigned branch wrong");

  property p_status_kept;
    @(posedge ref_clk) disable iff (srst)
      (issue && state_r == CBU_ST_IDLE) |=> (status_out_r == $past(status_in));
  endproperty
  a_status_kept: assert property (p_status_kept) else $error("status altered");

  // flags captured on accept must not move during the extra jump cycle
  property p_status_hold;
    @(posedge ref_clk) disable iff (srst)
      s_accept_taken |=> ##1 $stable(status_out_r);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status moved");

  // busy lasting longer would stretch a taken branch past two cycles
  property p_busy_once;
    @(posedge ref_clk) disable iff (srst)
      busy_r |=> !busy_r;
  endproperty
  a_busy_once: assert property (p_busy_once) else $error("busy over one cycle");

  // taken is only ever reported on the finishing cycle
  property p_taken_done;
    @(posedge ref_clk) disable iff (srst)
      taken_r |-> done_r;
  endproperty
  a_taken_done: assert property (p_taken_done) else $error("taken without done");

  // pc only moves together with a finish pulse; the edge after reset is exempt
  property p_pc_hold;
    @(posedge ref_clk) disable iff (srst)
      (!done_r && !$past(srst)) |-> $stable(pc_out_r);
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("pc moved between finishes");

  // a request in the busy cycle is dropped; only the held branch finishes
  property p_busy_ignore;
    @(posedge ref_clk) disable iff (srst)
      (busy_r && issue) |=> (done_r && taken_r && !busy_r);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("busy issue acted on");

  // a reset cut into a branch leaves no stray finish behind
  property p_reset_quiet;
    @(posedge ref_clk) disable iff (srst)
      $fell(srst) |-> (!busy_r && !done_r && !taken_r && pc_out_r == PC_RST);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("dirty reset state");
endmodule

// File: src/cbu_cond_eval.sv
// condition test and branch target for one conditional branch
`timescale 1ns/1ns
module cbu_cond_eval
  import cbu_pkg::*;
(
  input  wire logic [2:0]                 op,
  input  wire logic [cbu_pkg::IDX_W-1:0]  flag_idx,
  input  wire logic [cbu_pkg::STAT_W-1:0] status_register,
  input  wire logic [cbu_pkg::PC_W-1:0]   pc_in,
  input  wire logic [cbu_pkg::OFS_W-1:0]  offset,
  output logic                            cond_met,
  output logic [cbu_pkg::PC_W-1:0]        target
);
  // selected flags
  wire logic sel_bit = status_register[flag_idx];
  wire logic eq_bit  = status_register[STAT_EQ_BIT];
  wire logic ovf_bit = status_register[STAT_OVF_BIT];

  // sign extension keeps backward branches working
  wire logic [PC_W-1:0] ofs_ext = {{(PC_W-OFS_W){offset[OFS_W-1]}}, offset};

  // wraps at pc width, like the core's own counter
  assign target = pc_in + ofs_ext + PC_STEP;

  // condition per opcode; unknown codes never branch
  always_comb begin
    case (op)
      branch_on_flag_set:       cond_met = sel_bit;
      branch_on_flag_cleared:   cond_met = ~sel_bit;
      branch_if_equal:          cond_met = eq_bit;
      branch_if_unequal:        cond_met = ~eq_bit;
      branch_on_overflow_one:   cond_met = ovf_bit;
      branch_on_overflow_zero:  cond_met = ~ovf_bit;
      branch_unsigned_at_least: cond_met = ~ovf_bit;
      default:                  cond_met = 1'b0;
    endcase
  end
endmodule
